// File: logic/csf_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

module csf_bank #(
	parameter logic [6:0] I2C_ADDR = `CSF_I2C_ADDR
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial register bus pins
	input wire logic i2c_scl_in,
	input wire logic i2c_sda_in,
	output logic i2c_sda_out,
	output logic i2c_sda_oe,
	// Analog condition pins
	input wire csf_pkg::csf_live_t live_pins,
	input wire csf_pkg::csf_loop_t loop_pins,
	// Comparator setup and ADC results
	input wire csf_pkg::csf_cmp_t cmp,
	// Register contents for the charger core
	output logic [7:0] fault_temperature_status,
	output logic [7:0] alarm_open_status,
	output logic [7:0] charge_loop_event_flags,
	output logic input_good
);
	import csf_pkg::*;

	// ==========================================================
	// Pin synchronisers
	csf_live_t live_m_r, live_s_r;
	csf_loop_t loop_m_r, loop_s_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_m_r <= '0;
			live_s_r <= '0;
			loop_m_r <= '0;
			loop_s_r <= '0;
		end else begin
			live_m_r <= live_pins;
			live_s_r <= live_m_r;
			loop_m_r <= loop_pins;
			loop_s_r <= loop_m_r;
		end
	end

	// ==========================================================
	// Digital comparators
	function automatic logic cmp_meets(input logic above, input logic [`CSF_ADC_W-1:0] meas,
		input logic [`CSF_ADC_W-1:0] thr);
		cmp_meets = above ? (meas > thr) : (meas < thr);
	endfunction

	logic [`CSF_NUM_CMP-1:0] cmp_hit;

	genvar gk;
	generate
		for (gk = 0; gk < `CSF_NUM_CMP; gk++) begin : g_cmp
			assign cmp_hit[gk] = cmp_meets(cmp.comparator_direction_select[gk],
				cmp.meas[gk], cmp.thr[gk]);
		end
	endgenerate

	// ==========================================================
	// Serial register access
	logic rd_req;
	logic [7:0] rd_addr;
	logic [7:0] rdata_r, rdata_nxt;

	csf_i2c_target #(
		.ADDR(I2C_ADDR)
	) u_target (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(i2c_scl_in),
		.sda_in(i2c_sda_in),
		.sda_out(i2c_sda_out),
		.sda_oe(i2c_sda_oe),
		.rd_req(rd_req),
		.rd_addr(rd_addr),
		.rd_data(rdata_r)
	);

	// ==========================================================
	// Live status registers
	logic [7:0] fault_r, fault_nxt, alarm_r, alarm_nxt;

	always_comb begin
		fault_nxt = `CSF_STAT_RST;
		fault_nxt[`CSF_FB_OVP] = live_s_r.input_overvoltage_live;
		fault_nxt[`CSF_FB_OCP] = live_s_r.battery_overcurrent_live;
		fault_nxt[`CSF_FB_BATUV] = live_s_r.battery_undervoltage_live;
		// Cold wins over cool so the regions never overlap
		fault_nxt[`CSF_FB_COLD] = live_s_r.ts_above_cold;
		fault_nxt[`CSF_FB_COOL] = live_s_r.ts_above_cool & ~live_s_r.ts_above_cold;
		fault_nxt[`CSF_FB_WARM] = live_s_r.ts_below_warm & ~live_s_r.ts_below_hot;
		fault_nxt[`CSF_FB_HOT] = live_s_r.ts_below_hot;
		alarm_nxt = `CSF_STAT_RST;
		alarm_nxt[`CSF_AB_CMP1] = cmp_hit[0];
		alarm_nxt[`CSF_AB_CMP2] = cmp_hit[1];
		alarm_nxt[`CSF_AB_CMP3] = cmp_hit[2];
		alarm_nxt[`CSF_AB_OPEN] = live_s_r.ts_above_open;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_r <= `CSF_STAT_RST;
			alarm_r <= `CSF_STAT_RST;
		end else begin
			fault_r <= fault_nxt;
			alarm_r <= alarm_nxt;
		end
	end

	// ==========================================================
	// Event detection and clear-on-read flags
	logic good_c, good_d_r, taper_d_r;
	logic rd_clr;
	logic [7:0] set_vec;
	logic [7:0] flags_r, flags_nxt;

	assign good_c = loop_s_r.vin_above_uvlo & loop_s_r.vin_above_sleep & loop_s_r.vin_below_ovp;
	assign rd_clr = rd_req & (rd_addr == `CSF_OFS_FLAGS);

	always_comb begin
		set_vec = 8'h00;
		set_vec[`CSF_EB_TAPER] = loop_s_r.taper_active & ~taper_d_r;
		set_vec[`CSF_EB_DONE] = loop_s_r.done_active;
		set_vec[`CSF_EB_LIMIT] = loop_s_r.input_limit_active;
		set_vec[`CSF_EB_PPATH] = loop_s_r.power_path_active;
		set_vec[`CSF_EB_SAG] = loop_s_r.input_sag_active;
		set_vec[`CSF_EB_THERM] = loop_s_r.thermal_active;
		set_vec[`CSF_EB_GOOD] = good_c ^ good_d_r;
		// Set wins over the clear so an event in the read cycle survives
		flags_nxt = (rd_clr ? `CSF_FLAGS_RST : flags_r) | set_vec;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= `CSF_FLAGS_RST;
			good_d_r <= 1'b0;
			taper_d_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			good_d_r <= good_c;
			taper_d_r <= loop_s_r.taper_active;
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_req) begin
			unique case (rd_addr)
				`CSF_OFS_FAULT: rdata_nxt = fault_r;
				`CSF_OFS_ALARM: rdata_nxt = alarm_r;
				// Value before the clear is returned
				`CSF_OFS_FLAGS: rdata_nxt = flags_r;
				default: rdata_nxt = `CSF_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= `CSF_UNMAPPED;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign fault_temperature_status = fault_r;
	assign alarm_open_status = alarm_r;
	assign charge_loop_event_flags = flags_r;
	assign input_good = good_d_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ovp_live: assert property (fault_r[7] == $past(live_s_r.input_overvoltage_live) && !fault_r[6])
		else $error("overvoltage status wrong");
	a_ocp_live: assert property ($rose(live_s_r.battery_overcurrent_live) |=> fault_r[5] [*1] ##1 1)
		else $error("over-current status missed");
	a_uv_live: assert property ($fell(live_s_r.battery_undervoltage_live) |=> !fault_r[4])
		else $error("undervoltage status stuck");
	a_cold_live: assert property (fault_r[3] == $past(live_s_r.ts_above_cold))
		else $error("cold status wrong");
	a_cool_region: assert property (fault_r[2] |-> !fault_r[3] && $past(live_s_r.ts_above_cool))
		else $error("cool status wrong");
	a_warm_region: assert property (fault_r[1] == $past(live_s_r.ts_below_warm && !live_s_r.ts_below_hot))
		else $error("warm status wrong");
	a_hot_live: assert property (fault_r[0] == $past(live_s_r.ts_below_hot))
		else $error("hot status wrong");
	a_alarm_rsvd: assert property (alarm_r[7] == 1'b0 && alarm_r[3:1] == 3'h0)
		else $error("alarm reserved bits set");
	// ==========================================================
	// Comparator checks
	// The comparator inputs are not reset, so the edge after reset is skipped
	a_cmp_one: assert property ($past(rst_n) |-> alarm_r[6] ==
		$past(cmp.comparator_direction_select[0] ? (cmp.meas[0] > cmp.thr[0]) :
		(cmp.meas[0] < cmp.thr[0])))
		else $error("comparator one status wrong");
	a_cmp_two: assert property ($past(rst_n) |-> alarm_r[5] ==
		$past(cmp.comparator_direction_select[1] ? (cmp.meas[1] > cmp.thr[1]) :
		(cmp.meas[1] < cmp.thr[1])))
		else $error("comparator two status wrong");
	a_cmp_three: assert property ($past(rst_n) |-> alarm_r[4] ==
		$past(cmp.comparator_direction_select[2] ? (cmp.meas[2] > cmp.thr[2]) :
		(cmp.meas[2] < cmp.thr[2])))
		else $error("comparator three status wrong");

	// ==========================================================
	// Live status and flag checks
	a_open_live: assert property (alarm_r[0] == $past(live_s_r.ts_above_open))
		else $error("open thermistor status wrong");
	a_flag_clear: assert property (rd_clr && set_vec == 8'h00 |=> flags_r == 8'h00)
		else $error("flags not cleared by read");
	a_taper_entry: assert property ($rose(loop_s_r.taper_active) |=> flags_r[6])
		else $error("taper entry not flagged");
	a_done_flag: assert property (loop_s_r.done_active |=> flags_r[5])
		else $error("charge done not flagged");
	a_limit_flag: assert property (loop_s_r.input_limit_active |=> flags_r[4])
		else $error("input limit not flagged");
	a_ppath_flag: assert property (loop_s_r.power_path_active |=> flags_r[3])
		else $error("power path not flagged");
	a_sag_flag: assert property (rd_clr && !loop_s_r.input_sag_active |=> !flags_r[2])
		else $error("sag flag set without cause");
	a_therm_flag: assert property (loop_s_r.thermal_active |=> flags_r[1])
		else $error("thermal regulation not flagged");
	a_good_change: assert property ($changed(good_c) |=> flags_r[0])
		else $error("power good change not flagged");
	a_good_terms: assert property (input_good |-> $past(loop_s_r.vin_above_uvlo &&
		loop_s_r.vin_above_sleep && loop_s_r.vin_below_ovp))
		else $error("power good without all terms");
	a_read_fault: assert property (rd_req && rd_addr == 8'h01 |=> rdata_r == $past(fault_r))
		else $error("fault read data wrong");
	a_set_wins: assert property (rd_clr && set_vec != 8'h00 |=> (flags_r & $past(set_vec)) == $past(set_vec))
		else $error("event lost in clearing read");
	a_flag_hold: assert property (!rd_clr |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("flag dropped without read");
	a_ocp_fall: assert property ($fell(live_s_r.battery_overcurrent_live) |=> !fault_r[5])
		else $error("over-current status stuck");
	a_uv_rise: assert property ($rose(live_s_r.battery_undervoltage_live) |=> fault_r[4])
		else $error("undervoltage status missed");
	a_flags_rsvd: assert property (flags_r[7] == 1'b0)
		else $error("reserved flag bit set");
	// A flag may only rise when its cause was seen the cycle before
	a_flag_cause: assert property ((flags_r & ~$past(flags_r) & ~$past(set_vec)) == 8'h00)
		else $error("flag set without cause");
	// A taper phase that is still running must not re-arm after the read
	a_taper_rearm: assert property (rd_clr && loop_s_r.taper_active && taper_d_r |=>
		!flags_r[6])
		else $error("held taper re-armed its flag");
	a_good_reg: assert property (input_good == $past(good_c))
		else $error("power good output wrong");

	// ==========================================================
	// Read path checks
	a_read_alarm: assert property (rd_req && rd_addr == `CSF_OFS_ALARM |=>
		rdata_r == $past(alarm_r))
		else $error("alarm read data wrong");
	// The host must see the flags as they were before the clear
	a_read_flags: assert property (rd_req && rd_addr == `CSF_OFS_FLAGS |=>
		rdata_r == $past(flags_r))
		else $error("flag read data wrong");
	a_read_unmapped: assert property (rd_req && (rd_addr == 8'h00 || rd_addr > `CSF_OFS_FLAGS) |=>
		rdata_r == `CSF_UNMAPPED)
		else $error("unmapped read data wrong");
	a_req_pulse: assert property (rd_req |=> !rd_req)
		else $error("read request longer than a cycle");
	a_rdata_hold: assert property (!rd_req |=> $stable(rdata_r))
		else $error("read data moved without request");

endmodule

`default_nettype wire

// File: include/csf_params.svh
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ==========================================================
// Register offsets, also the serial register addresses
`define CSF_OFS_FAULT 8'h01
`define CSF_OFS_ALARM 8'h02
`define CSF_OFS_FLAGS 8'h03

// ==========================================================
// Fault and temperature status bit positions
`define CSF_FB_OVP 7
`define CSF_FB_RSVD 6
`define CSF_FB_OCP 5
`define CSF_FB_BATUV 4
`define CSF_FB_COLD 3
`define CSF_FB_COOL 2
`define CSF_FB_WARM 1
`define CSF_FB_HOT 0

// ==========================================================
// Alarm and open thermistor status bit positions
`define CSF_AB_RSVD 7
`define CSF_AB_CMP1 6
`define CSF_AB_CMP2 5
`define CSF_AB_CMP3 4
`define CSF_AB_OPEN 0

// ==========================================================
// Charge loop event flag bit positions
`define CSF_EB_RSVD 7
`define CSF_EB_TAPER 6
`define CSF_EB_DONE 5
`define CSF_EB_LIMIT 4
`define CSF_EB_PPATH 3
`define CSF_EB_SAG 2
`define CSF_EB_THERM 1
`define CSF_EB_GOOD 0

// ==========================================================
// Reset values and widths
`define CSF_FLAGS_RST 8'h00
`define CSF_STAT_RST 8'h00
`define CSF_UNMAPPED 8'h00
`define CSF_ADC_W 16
`define CSF_NUM_CMP 3
// Target address is arbitrary
`define CSF_I2C_ADDR 7'h2a

`endif

// File: include/csf_pkg.sv
`include "csf_params.svh"

package csf_pkg;

	// ==========================================================
	// Asynchronous condition pins from the analog front end
	typedef struct packed {
		logic input_overvoltage_live;
		logic battery_overcurrent_live;
		logic battery_undervoltage_live;
		logic ts_above_cold;
		logic ts_above_cool;
		logic ts_below_warm;
		logic ts_below_hot;
		logic ts_above_open;
	} csf_live_t;

	typedef struct packed {
		logic taper_active;
		logic done_active;
		logic input_limit_active;
		logic power_path_active;
		logic input_sag_active;
		logic thermal_active;
		logic vin_above_uvlo;
		logic vin_above_sleep;
		logic vin_below_ovp;
	} csf_loop_t;

	// ==========================================================
	// Comparator setup and measurements, same clock domain
	typedef struct packed {
		logic [`CSF_NUM_CMP-1:0] comparator_direction_select;
		logic [`CSF_NUM_CMP-1:0][`CSF_ADC_W-1:0] meas;
		logic [`CSF_NUM_CMP-1:0][`CSF_ADC_W-1:0] thr;
	} csf_cmp_t;

	typedef enum logic [6:0] {
		CSF_IDLE = 7'b0000001,
		CSF_ADDR = 7'b0000010,
		CSF_ADDR_ACK = 7'b0000100,
		CSF_PTR = 7'b0001000,
		CSF_PTR_ACK = 7'b0010000,
		CSF_TX = 7'b0100000,
		CSF_TX_ACK = 7'b1000000
	} csf_i2c_st_t;

endpackage

// File: logic/csf_i2c_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

module csf_i2c_target #(
	parameter logic [6:0] ADDR = `CSF_I2C_ADDR
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Register read port
	output logic rd_req,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	import csf_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection
	logic [1:0] scl_sy_r, sda_sy_r;
	logic scl_d_r, sda_d_r;
	logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sy_r <= 2'h3;
			sda_sy_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_sy_r <= {scl_sy_r[0], scl_in};
			sda_sy_r <= {sda_sy_r[0], sda_in};
			scl_d_r <= scl_sy_r[1];
			sda_d_r <= sda_sy_r[1];
		end
	end

	assign scl = scl_sy_r[1];
	assign sda = sda_sy_r[1];
	assign scl_rise = scl & ~scl_d_r;
	assign scl_fall = ~scl & scl_d_r;
	assign start_c = scl & scl_d_r & sda_d_r & ~sda;
	assign stop_c = scl & scl_d_r & ~sda_d_r & sda;

	// ==========================================================
	// Byte engine
	csf_i2c_st_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, addr_r, addr_nxt;
	logic rw_r, rw_nxt, first_r, first_nxt, nack_r, nack_nxt;
	logic req_r, req_nxt, load_r;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		rw_nxt = rw_r;
		ptr_nxt = ptr_r;
		addr_nxt = addr_r;
		first_nxt = first_r;
		nack_nxt = nack_r;
		req_nxt = 1'b0;
		// Data from the bank arrives one cycle after the request
		tx_nxt = load_r ? rd_data : tx_r;
		if (start_c) begin
			st_nxt = CSF_ADDR;
			cnt_nxt = 4'h0;
		end else if (stop_c) begin
			st_nxt = CSF_IDLE;
		end else begin
			unique case (st_r)
				CSF_IDLE: begin
				end
				CSF_ADDR, CSF_PTR: begin
					if (scl_rise) begin
						sh_nxt = {sh_r[6:0], sda};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						cnt_nxt = 4'h0;
						if (st_r == CSF_ADDR) begin
							if (sh_r[7:1] == ADDR) begin
								st_nxt = CSF_ADDR_ACK;
								rw_nxt = sh_r[0];
								first_nxt = 1'b1;
							end else begin
								st_nxt = CSF_IDLE;
							end
						end else begin
							// Only the first written byte moves the pointer
							st_nxt = CSF_PTR_ACK;
							if (first_r) begin
								ptr_nxt = sh_r;
							end
							first_nxt = 1'b0;
						end
					end
				end
				CSF_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_r) begin
							st_nxt = CSF_TX;
							req_nxt = 1'b1;
							addr_nxt = ptr_r;
							ptr_nxt = ptr_r + 8'h01;
						end else begin
							st_nxt = CSF_PTR;
						end
					end
				end
				CSF_PTR_ACK: begin
					if (scl_fall) begin
						st_nxt = CSF_PTR;
					end
				end
				CSF_TX: begin
					if (scl_fall) begin
						if (cnt_r == 4'h7) begin
							st_nxt = CSF_TX_ACK;
							cnt_nxt = 4'h0;
						end else begin
							cnt_nxt = cnt_r + 4'h1;
							tx_nxt = {tx_r[6:0], 1'b0};
						end
					end
				end
				CSF_TX_ACK: begin
					if (scl_rise) begin
						nack_nxt = sda;
					end else if (scl_fall) begin
						if (nack_r) begin
							st_nxt = CSF_IDLE;
						end else begin
							st_nxt = CSF_TX;
							req_nxt = 1'b1;
							addr_nxt = ptr_r;
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				default: begin
					st_nxt = CSF_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= CSF_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'hff;
			ptr_r <= 8'h00;
			addr_r <= 8'h00;
			rw_r <= 1'b0;
			first_r <= 1'b0;
			nack_r <= 1'b1;
			req_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			addr_r <= addr_nxt;
			rw_r <= rw_nxt;
			first_r <= first_nxt;
			nack_r <= nack_nxt;
			req_r <= req_nxt;
			load_r <= req_r;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = (st_r == CSF_ADDR_ACK) | (st_r == CSF_PTR_ACK) | ((st_r == CSF_TX) & ~tx_r[7]);
	assign rd_req = req_r;
	assign rd_addr = addr_r;

endmodule

`default_nettype wire

// File: verif/csf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

// ==========================================================
// Serial bus host that reads the status and flag registers
module csf_host_model #(
	parameter logic [6:0] ADDR = `CSF_I2C_ADDR
) (
	// Clock
	input wire logic clk,
	// Bus pins, data is open drain with a pull-up
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// Each phase is twice the target's minimum, to leave margin for its sync
	localparam int HALF = 8;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic start_cond;
		sda_pull <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		sda_pull <= 1'b1;
		tick(HALF);
		scl <= 1'b0;
		tick(HALF / 2);
	endtask

	task automatic stop_cond;
		sda_pull <= 1'b1;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		sda_pull <= 1'b0;
		tick(HALF);
	endtask

	// Data only moves while the clock is low
	task automatic put_bit(input logic b);
		sda_pull <= ~b;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		scl <= 1'b0;
		tick(HALF / 2);
	endtask

	// Sampled at the end of the high phase, where the target's bit has settled
	task automatic get_bit(output logic b);
		sda_pull <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		b = sda;
		scl <= 1'b0;
		tick(HALF / 2);
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = (b === 1'b0);
	endtask

	task automatic probe(input logic [6:0] a, output logic ack);
		start_cond;
		put_byte({a, 1'b0}, ack);
		stop_cond;
	endtask

	// Pointer write, repeated start, n bytes read, last one refused
	task automatic read_regs(input logic [7:0] ptr, input int n, output logic [31:0] d,
		output logic ok);
		logic a0, a1, a2, b;
		logic [7:0] v;
		d = 32'h0;
		start_cond;
		put_byte({ADDR, 1'b0}, a0);
		put_byte(ptr, a1);
		start_cond;
		put_byte({ADDR, 1'b1}, a2);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				get_bit(b);
				v[i] = b;
			end
			put_bit(k == n - 1);
			d = {d[23:0], v};
		end
		stop_cond;
		ok = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

// File: verif/csf_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "csf_params.svh"

// ==========================================================
// Bench for the status and event flag bank
module csf_bank_tb;
	import csf_pkg::*;
	logic clk, rst_n, scl, host_pull, sda_oe, input_good;
	logic sda_out;
	logic [7:0] fault_word, alarm_word, flag_word;
	wire sda;
	csf_live_t live_pins;
	csf_loop_t loop_pins;
	csf_cmp_t cmp;
	int n_fail, compares;

	// Open drain: released line reads the pull-up level
	assign sda = ~host_pull & (sda_oe ? sda_out : 1'b1);

	csf_bank u_csf_bank (.clk(clk), .rst_n(rst_n), .i2c_scl_in(scl), .i2c_sda_in(sda),
		.i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe), .live_pins(live_pins), .loop_pins(loop_pins),
		.cmp(cmp), .fault_temperature_status(fault_word), .alarm_open_status(alarm_word),
		.charge_loop_event_flags(flag_word), .input_good(input_good));

	csf_host_model u_csf_host_model (.clk(clk), .scl(scl), .sda_pull(host_pull), .sda(sda));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// ==========================================================
	// Checking and expectations
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	function automatic logic [7:0] exp_fault(input csf_live_t l);
		return {l.input_overvoltage_live, 1'b0, l.battery_overcurrent_live,
			l.battery_undervoltage_live, l.ts_above_cold, l.ts_above_cool & ~l.ts_above_cold,
			l.ts_below_warm & ~l.ts_below_hot, l.ts_below_hot};
	endfunction

	function automatic logic [7:0] exp_alarm(input csf_live_t l, input csf_cmp_t c);
		logic [2:0] hit;
		for (int k = 0; k < 3; k++) begin
			hit[k] = c.comparator_direction_select[k] ? (c.meas[k] > c.thr[k]) :
				(c.meas[k] < c.thr[k]);
		end
		return {1'b0, hit[0], hit[1], hit[2], 3'b000, l.ts_above_open};
	endfunction

	task automatic rd(input logic [7:0] ptr, input int n, input logic [31:0] exp);
		logic [31:0] d;
		logic ok;
		u_csf_host_model.read_regs(ptr, n, d, ok);
		chk(32'(ok), 32'h1);
		chk(d, exp);
	endtask

	task automatic settle;
		repeat (6) @(posedge clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rd(`CSF_OFS_FLAGS, 1, 32'h0);
		rd(`CSF_OFS_FAULT, 3, 32'h0);
	endtask

	task automatic t_fault;
		csf_live_t l;
		logic [7:0] tail [3] = '{8'h18, 8'h06, 8'hff};
		for (int i = 0; i < 11; i++) begin
			l = (i < 8) ? csf_live_t'(8'h01 << i) : csf_live_t'(tail[i - 8]);
			live_pins <= l;
			settle;
			chk({24'h0, fault_word}, {24'h0, exp_fault(l)});
			rd(`CSF_OFS_FAULT, 2, {16'h0, exp_fault(l), exp_alarm(l, cmp)});
		end
		live_pins <= '0;
	endtask

	// Equal values probe the strict compare in both directions
	task automatic t_cmp;
		csf_cmp_t c;
		c.meas = {16'h0001, 16'h1000, 16'h8000};
		c.thr = {16'h0002, 16'h1000, 16'h7fff};
		for (int j = 0; j < 8; j++) begin
			c.comparator_direction_select = 3'(j);
			c.thr[1] = j[0] ? 16'h0fff : 16'h1000;
			cmp <= c;
			settle;
			chk({24'h0, alarm_word}, {24'h0, exp_alarm('0, c)});
			rd(`CSF_OFS_ALARM, 1, {24'h0, exp_alarm('0, c)});
		end
	endtask

	task automatic t_events;
		for (int b = 1; b < 7; b++) begin
			loop_pins[b + 2] <= 1'b1;
			repeat (4) @(posedge clk);
			loop_pins[b + 2] <= 1'b0;
			settle;
			chk({24'h0, flag_word}, 32'h1 << b);
			rd(`CSF_OFS_FLAGS, 1, 32'h1 << b);
			rd(`CSF_OFS_FLAGS, 1, 32'h0);
		end
	endtask

	// Taper held on must not re-arm, thermal held on must survive each clear
	task automatic t_held;
		loop_pins <= 9'h108;
		settle;
		rd(`CSF_OFS_FLAGS, 1, 32'h42);
		rd(`CSF_OFS_FLAGS, 1, 32'h02);
		loop_pins <= '0;
		settle;
		rd(`CSF_OFS_FLAGS, 1, 32'h02);
		rd(`CSF_OFS_FLAGS, 1, 32'h0);
	endtask

	task automatic t_good;
		for (int t = 0; t < 3; t++) begin
			loop_pins <= 9'h007;
			settle;
			chk(32'(input_good), 32'h1);
			rd(`CSF_OFS_FLAGS, 1, 32'h1);
			loop_pins[t] <= 1'b0;
			settle;
			chk(32'(input_good), 32'h0);
			rd(`CSF_OFS_FLAGS, 1, 32'h1);
		end
		loop_pins <= '0;
		settle;
		rd(`CSF_OFS_FLAGS, 1, 32'h0);
	endtask

	task automatic t_refuse;
		logic ack;
		u_csf_host_model.probe(7'(`CSF_I2C_ADDR ^ 7'h01), ack);
		chk(32'(ack), 32'h0);
		rd(8'h00, 1, 32'h0);
		loop_pins <= 9'h008;
		settle;
		loop_pins <= '0;
		settle;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`CSF_OFS_FLAGS, 1, 32'h0);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		n_fail = 0;
		compares = 0;
		rst_n = 1'b0;
		live_pins = '0;
		loop_pins = '0;
		cmp = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset;
		t_fault;
		t_cmp;
		t_events;
		t_held;
		t_good;
		t_refuse;
		give_verdict;
	end

	// About three times the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		give_verdict;
	end
endmodule
`default_nettype wire
